// file: hdl/fsp_group_dec.sv
// module: maps the nine upper address bits of a bottom-boot part to a protection group
`timescale 1ns/10ps
module fsp_group_dec (
	input wire logic [8:0] addr_hi,
	output logic [4:0] group,
	output logic outer_boot
);
	// groups 0..7 boot sectors, 8 the 3x64K block, 9..22 the 4x64K blocks, 23 the 3x64K block, 24 the top sector
	always_comb begin
		if (addr_hi[8:3] == 6'h00) begin
			group = {2'h0, addr_hi[2:0]};
		end else if (addr_hi[8:5] == 4'h0) begin
			group = 5'h08;
		end else if (addr_hi[8:5] != 4'hF) begin
			group = 5'(5'h08 + {1'b0, addr_hi[8:5]});
		end else if (addr_hi[4:3] == 2'h3) begin
			group = 5'h18;
		end else begin
			group = 5'h17;
		end
	end
	assign outer_boot = (group < fsp_pkg::GRP_OUTER_N);
endmodule : fsp_group_dec

// file: hdl/fsp_host_ctrl.sv
// module: host controller driving a parallel flash through its protection, write-guard and secured-region procedures
`timescale 1ns/10ps
module fsp_host_ctrl #(
	parameter logic [20:0] UNLOCK_A1 = 21'h00_0555,
	parameter logic [20:0] UNLOCK_A2 = 21'h00_02AA,
	parameter logic [7:0] UNLOCK_D1 = 8'hAA,
	parameter logic [7:0] UNLOCK_D2 = 8'h55,
	parameter logic [7:0] ENTER_CODE = 8'h88,
	parameter logic [7:0] EXIT_CODE1 = 8'h90,
	parameter logic [7:0] EXIT_CODE2 = 8'h00,
	parameter logic [7:0] PROTECT_CODE = 8'h60,
	parameter int unsigned STROBE_CYC = fsp_pkg::STROBE_CYC,
	parameter int unsigned RST_CYC = fsp_pkg::RST_PULSE_CYC
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [20:0] fl_addr,
	output logic [7:0] fl_dq_o,
	output logic fl_dq_oe,
	input wire logic [7:0] fl_dq_i,
	output logic fl_ce_n,
	output logic fl_oe_n,
	output logic fl_we_n,
	output logic fl_reset_n,
	output logic fl_reset_hv_en,
	output logic write_guard_accel_pin
);
	fsp_pkg::fsp_state_e state_q;
	logic [7:0] ahb_ofs_q;
	logic ahb_wr_q;
	logic [1:0] ctrl_q;
	logic [20:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic [2:0] op_q;
	logic [2:0] step_q;
	logic [15:0] cnt_q;
	logic err_q;
	logic secured_q;
	logic [24:0] shadow_q;
	logic [4:0] grp;
	logic outer;
	logic cmd_wr;
	logic [2:0] cmd_op;
	logic refuse;
	logic [29:0] cur_word;
	logic cur_last;

	// address, data and last-step flag of one bus cycle of an operation
	function automatic logic [29:0] seq_word(input logic [2:0] op, input logic [2:0] step,
			input logic [20:0] a, input logic [7:0] d);
		logic [29:0] w;
		w = {a, d, 1'b1};
		case (op)
			fsp_pkg::OP_PROTECT: w = {a[20:12], 5'h00, 7'h02, PROTECT_CODE, 1'b1};
			fsp_pkg::OP_UNPROT: w = {a[20:12], 5'h00, 7'h42, PROTECT_CODE, 1'b1};
			fsp_pkg::OP_VERIFY: w = {a[20:12], 5'h00, 7'h02, 8'h00, 1'b1};
			fsp_pkg::OP_ENTER, fsp_pkg::OP_EXIT: begin
				case (step)
					3'h0: w = {UNLOCK_A1, UNLOCK_D1, 1'b0};
					3'h1: w = {UNLOCK_A2, UNLOCK_D2, 1'b0};
					3'h2: w = {UNLOCK_A1, (op == fsp_pkg::OP_ENTER) ? ENTER_CODE : EXIT_CODE1,
						op == fsp_pkg::OP_ENTER};
					default: w = {21'h00_0000, EXIT_CODE2, 1'b1};
				endcase
			end
			default: w = {a, d, 1'b1};
		endcase
		return w;
	endfunction : seq_word

	fsp_group_dec u_dec (
		.addr_hi(addr_q[20:12]),
		.group(grp),
		.outer_boot(outer)
	);

	assign cur_word = seq_word(op_q, step_q, addr_q, wdata_q);
	assign cur_last = cur_word[0];
	assign cmd_wr = ahb_wr_q && (ahb_ofs_q == fsp_pkg::OFS_CMD);
	assign cmd_op = hwdata[2:0];
	// refused: busy, protect ops without high voltage, unprotect with any group open, off-boot access in overlay
	assign refuse = (state_q != fsp_pkg::S_IDLE)
		|| ((cmd_op == fsp_pkg::OP_PROTECT || cmd_op == fsp_pkg::OP_UNPROT) && !ctrl_q[fsp_pkg::CTRL_HV_BIT])
		|| ((cmd_op == fsp_pkg::OP_UNPROT) && (shadow_q != {fsp_pkg::GRP_N{1'b1}}))
		|| (secured_q && (grp >= fsp_pkg::GRP_BOOT_N) && (cmd_op <= fsp_pkg::OP_UNPROT));

	// ahb-lite slave, zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ahb_wr_q <= 1'b0;
			ahb_ofs_q <= 8'h00;
		end else if (clk_en && hready) begin
			ahb_wr_q <= hsel && htrans[1] && hwrite;
			ahb_ofs_q <= haddr[7:0];
		end
	end
	always_comb begin
		case (ahb_ofs_q)
			fsp_pkg::OFS_CTRL: hrdata = {30'h0000_0000, ctrl_q};
			fsp_pkg::OFS_ADDR: hrdata = {11'h000, addr_q};
			fsp_pkg::OFS_DATA: hrdata = {24'h00_0000, rdata_q};
			fsp_pkg::OFS_CMD: hrdata = {29'h0000_0000, op_q};
			fsp_pkg::OFS_STATUS: hrdata = {29'h0000_0000, secured_q, err_q, state_q != fsp_pkg::S_IDLE};
			fsp_pkg::OFS_SHADOW: hrdata = {7'h00, shadow_q};
			default: hrdata = 32'h0000_0000;
		endcase
	end

	// control register: guard level always driven from reset onward
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_q <= fsp_pkg::CTRL_RESET;
			addr_q <= 21'h00_0000;
			wdata_q <= 8'h00;
		end else if (clk_en && ahb_wr_q) begin
			if (ahb_ofs_q == fsp_pkg::OFS_CTRL) ctrl_q <= hwdata[1:0];
			if (ahb_ofs_q == fsp_pkg::OFS_ADDR) addr_q <= hwdata[20:0];
			if (ahb_ofs_q == fsp_pkg::OFS_DATA) wdata_q <= hwdata[7:0];
		end
	end
	assign write_guard_accel_pin = ctrl_q[fsp_pkg::CTRL_GUARD_BIT];
	assign fl_reset_hv_en = ctrl_q[fsp_pkg::CTRL_HV_BIT];

	// bus cycle sequencer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= fsp_pkg::S_IDLE;
			op_q <= fsp_pkg::OP_WRITE;
			step_q <= 3'h0;
			cnt_q <= 16'h0000;
		end else if (clk_en) begin
			case (state_q)
				fsp_pkg::S_IDLE: begin
					if (cmd_wr && !refuse) begin
						op_q <= cmd_op;
						step_q <= 3'h0;
						cnt_q <= 16'h0000;
						state_q <= (cmd_op == fsp_pkg::OP_HWRESET) ? fsp_pkg::S_RST : fsp_pkg::S_SETUP;
					end
				end
				fsp_pkg::S_SETUP: state_q <= fsp_pkg::S_STROBE;
				fsp_pkg::S_STROBE: begin
					cnt_q <= 16'(cnt_q + 16'h0001);
					if (cnt_q == 16'(STROBE_CYC - 1)) begin
						state_q <= fsp_pkg::S_HOLD;
					end
				end
				fsp_pkg::S_HOLD: begin
					cnt_q <= 16'h0000;
					step_q <= 3'(step_q + 3'h1);
					state_q <= cur_last ? fsp_pkg::S_IDLE : fsp_pkg::S_SETUP;
				end
				fsp_pkg::S_RST: begin
					cnt_q <= 16'(cnt_q + 16'h0001);
					if (cnt_q == 16'(RST_CYC - 1)) begin
						state_q <= fsp_pkg::S_IDLE;
					end
				end
				default: state_q <= fsp_pkg::S_IDLE;
			endcase
		end
	end

	// error flag, reloaded on every command write: set when the command is refused, cleared when it is accepted
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			err_q <= 1'b0;
		end else if (clk_en && cmd_wr) begin
			err_q <= refuse;
		end
	end

	// read data and protection shadow; data bus taken on the last strobe cycle, output enable still low
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
			shadow_q <= {fsp_pkg::GRP_N{1'b0}};
		end else if (clk_en) begin
			if (state_q == fsp_pkg::S_STROBE && cnt_q == 16'(STROBE_CYC - 1)) begin
				if (op_q == fsp_pkg::OP_READ || op_q == fsp_pkg::OP_VERIFY) rdata_q <= fl_dq_i;
				if (op_q == fsp_pkg::OP_VERIFY) shadow_q[grp] <= (fl_dq_i != 8'h00);
			end
			if (state_q == fsp_pkg::S_HOLD) begin
				if (op_q == fsp_pkg::OP_PROTECT) shadow_q[grp] <= 1'b1;
				if (op_q == fsp_pkg::OP_UNPROT) shadow_q <= {fsp_pkg::GRP_N{1'b0}};
			end
		end
	end

	// secured-region overlay tracking
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			secured_q <= 1'b0;
		end else if (clk_en) begin
			if (state_q == fsp_pkg::S_RST) secured_q <= 1'b0;
			else if (state_q == fsp_pkg::S_HOLD && cur_last && op_q == fsp_pkg::OP_ENTER) secured_q <= 1'b1;
			else if (state_q == fsp_pkg::S_HOLD && cur_last && op_q == fsp_pkg::OP_EXIT) secured_q <= 1'b0;
		end
	end

	// pin drive, all from flip-flops or the state register
	logic is_rd;
	assign is_rd = (op_q == fsp_pkg::OP_READ) || (op_q == fsp_pkg::OP_VERIFY);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			fl_addr <= 21'h00_0000;
			fl_dq_o <= 8'h00;
		end else if (clk_en && state_q == fsp_pkg::S_IDLE && cmd_wr && !refuse) begin
			fl_addr <= addr_q;
		end else if (clk_en && state_q == fsp_pkg::S_SETUP) begin
			fl_addr <= cur_word[29:9];
			fl_dq_o <= cur_word[8:1];
		end
	end
	assign fl_ce_n = !(state_q == fsp_pkg::S_STROBE || state_q == fsp_pkg::S_HOLD);
	assign fl_we_n = !(state_q == fsp_pkg::S_STROBE && !is_rd);
	assign fl_oe_n = !(state_q == fsp_pkg::S_STROBE && is_rd);
	assign fl_dq_oe = !fl_ce_n && !is_rd;
	assign fl_reset_n = (state_q != fsp_pkg::S_RST);

	a_busy_refuse: assert property (@(posedge core_clk) disable iff (sys_rst)
		(clk_en && cmd_wr && state_q != fsp_pkg::S_IDLE) |=> err_q)
		else $error("command accepted while busy");
	a_unprot_guard: assert property (@(posedge core_clk) disable iff (sys_rst)
		($fell(fl_we_n) && op_q == fsp_pkg::OP_UNPROT) |-> (shadow_q == {fsp_pkg::GRP_N{1'b1}}))
		else $error("unprotect issued with an open group");
	a_unprot_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
		(clk_en && state_q == fsp_pkg::S_HOLD && op_q == fsp_pkg::OP_UNPROT) |=> (shadow_q == 25'h000_0000))
		else $error("unprotect left a group marked");
	a_hv_protect: assert property (@(posedge core_clk) disable iff (sys_rst)
		(!fl_we_n && (op_q == fsp_pkg::OP_PROTECT || op_q == fsp_pkg::OP_UNPROT)) |-> fl_reset_hv_en)
		else $error("protect cycle without reset high voltage");
	a_reset_exit: assert property (@(posedge core_clk) disable iff (sys_rst)
		(clk_en && !fl_reset_n) |=> !secured_q)
		else $error("overlay survived hardware reset");
	a_secured_block: assert property (@(posedge core_clk) disable iff (sys_rst)
		($fell(fl_ce_n) && secured_q && op_q <= fsp_pkg::OP_UNPROT) |-> (grp < fsp_pkg::GRP_BOOT_N))
		else $error("array access while overlay active");
	a_strobe_excl: assert property (@(posedge core_clk) disable iff (sys_rst)
		!fl_we_n |-> (fl_oe_n && !fl_ce_n && fl_dq_oe && fl_reset_n))
		else $error("write strobe with bad companion pins");
	a_enter_seq: assert property (@(posedge core_clk) disable iff (sys_rst)
		(clk_en && state_q == fsp_pkg::S_HOLD && op_q == fsp_pkg::OP_ENTER && step_q == 3'h2) |=> secured_q)
		else $error("enter sequence did not set overlay");
endmodule : fsp_host_ctrl

// file: hdl/fsp_pkg.sv
// package: register map, operation codes and timing counts of the flash protection host controller
package fsp_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned STROBE_NS = 40;
	localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RST_PULSE_NS = 500;
	localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_SHADOW = 8'h14;
	localparam int unsigned CTRL_GUARD_BIT = 0;
	localparam int unsigned CTRL_HV_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_ERR_BIT = 1;
	localparam int unsigned ST_SECURED_BIT = 2;
	localparam int unsigned ADDR_W = 21;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned GRP_N = 25;
	localparam int unsigned GRP_W = 5;
	localparam logic [4:0] GRP_BOOT_N = 5'h08;
	localparam logic [4:0] GRP_OUTER_N = 5'h02;
	localparam logic [2:0] OP_WRITE = 3'h0;
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_VERIFY = 3'h2;
	localparam logic [2:0] OP_PROTECT = 3'h3;
	localparam logic [2:0] OP_UNPROT = 3'h4;
	localparam logic [2:0] OP_ENTER = 3'h5;
	localparam logic [2:0] OP_EXIT = 3'h6;
	localparam logic [2:0] OP_HWRESET = 3'h7;
	typedef enum logic [4:0] {
		S_IDLE = 5'b0_0001,
		S_SETUP = 5'b0_0010,
		S_STROBE = 5'b0_0100,
		S_HOLD = 5'b0_1000,
		S_RST = 5'b1_0000
	} fsp_state_e;
endpackage : fsp_pkg

// file: tb/fsp_flash_model.sv
// flash partner model: group protection, write guard, temporary unprotect and secured overlay
`timescale 1ns/10ps
module fsp_flash_model #(
	parameter logic [7:0] SEC_BYTE = 8'hC3,
	parameter bit FACTORY_LOCK = 1'b0
) (
	input wire logic [20:0] fl_addr,
	input wire logic [7:0] fl_dq_o,
	input wire logic fl_dq_oe,
	output logic [7:0] fl_dq_i,
	input wire logic fl_ce_n,
	input wire logic fl_oe_n,
	input wire logic fl_we_n,
	input wire logic fl_reset_n,
	input wire logic fl_reset_hv_en,
	input wire logic write_guard_accel_pin
);
	logic [24:0] prot = 25'h000_0000;
	logic [7:0] mem [25];
	logic [7:0] sec = SEC_BYTE;
	logic secured = 1'b0;
	logic [7:0] rd;
	logic [7:0] last_rd = 8'h00;
	logic [4:0] g;
	// group decode of the nine upper address bits
	function automatic logic [4:0] grp(input logic [8:0] h);
		if (h[8:3] == 6'h00) return {2'b00, h[2:0]};
		if (h[8:5] == 4'h0) return 5'h08;
		if (h[8:5] != 4'hF) return 5'h08 + {1'b0, h[8:5]};
		if (h[8:3] != 6'h3F) return 5'h17;
		return 5'h18;
	endfunction : grp
	assign g = grp(fl_addr[20:12]);
	initial begin
		for (int i = 0; i < 25; i++) mem[i] = 8'hFF;
	end
	always @(posedge fl_we_n) begin
		if (!fl_ce_n && fl_dq_oe) begin
			if (fl_addr[11:0] == 12'h100) begin
				if (secured && g < 5'h08) begin
					if (!FACTORY_LOCK) sec = fl_dq_o;
				end else if (!(prot[g] && !fl_reset_hv_en) && !(g < 5'h02 && !write_guard_accel_pin)) begin
					mem[g] = fl_dq_o;
				end
			end else if (fl_dq_o == 8'h60 && fl_reset_hv_en) begin
				if (fl_addr[6]) prot = 25'h000_0000;
				else prot[g] = 1'b1;
			end else if (fl_dq_o == 8'h88) secured = 1'b1;
			else if (fl_dq_o == 8'h90) secured = 1'b0;
		end
	end
	always @(negedge fl_reset_n) secured = 1'b0;
	always @* begin
		if (fl_addr[11:0] == 12'h002) rd = {7'h00, prot[g]};
		else if (fl_addr[11:0] == 12'h003) rd = {FACTORY_LOCK, 7'h01};
		else if (secured && g < 5'h08) rd = sec;
		else rd = mem[g];
	end
	// released bus shows the inverse of the last byte
	assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? rd : ~last_rd;
	always @(posedge fl_oe_n) last_rd = rd;
endmodule : fsp_flash_model

// file: tb/testbench.sv
// testbench: drives the controller over the register bus against the flash model
`timescale 1ns/10ps
module testbench;
	typedef struct {logic [1:0] ctrl; logic [8:0] hi; logic [7:0] wd; logic [7:0] exp;} fsp_row_s;
	localparam logic [8:0] MAP_HI [12] = '{9'h000, 9'h007, 9'h008, 9'h01F, 9'h020, 9'h03F,
		9'h100, 9'h1DF, 9'h1E0, 9'h1F7, 9'h1F8, 9'h1FF};
	localparam int MAP_G [12] = '{0, 7, 8, 8, 9, 9, 16, 22, 23, 23, 24, 24};
	fsp_row_s rows [7] = '{'{2'b01, 9'h000, 8'hA5, 8'hA5}, '{2'b00, 9'h001, 8'h11, 8'hFF},
		'{2'b00, 9'h003, 8'h22, 8'h22}, '{2'b01, 9'h002, 8'h33, 8'hFF}, '{2'b11, 9'h002, 8'h44, 8'h44},
		'{2'b10, 9'h000, 8'h5A, 8'hA5}, '{2'b01, 9'h002, 8'h66, 8'h44}};
	logic core_clk;
	logic sys_rst;
	logic hwrite;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [1:0] htrans;
	logic hreadyout;
	logic hresp;
	logic clk_en;
	logic [20:0] fl_addr;
	logic [7:0] fl_dq_o;
	logic [7:0] fl_dq_i;
	logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_reset_hv_en, guard;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [31:0] st;
	logic [31:0] mask;
	fsp_host_ctrl #(.RST_CYC(4)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
		.fl_reset_n(fl_reset_n), .fl_reset_hv_en(fl_reset_hv_en), .write_guard_accel_pin(guard));
	fsp_flash_model u_flash (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
		.fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n),
		.fl_reset_hv_en(fl_reset_hv_en), .write_guard_accel_pin(guard));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		samples_checked++;
		if (v !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, v);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask : wr
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0000_0000, x);
		chk(nm, e, x);
	endtask : rchk
	task automatic cmd(input logic [2:0] op, input logic [20:0] a, input logic [7:0] d);
		wr(fsp_pkg::OFS_ADDR, {11'h000, a});
		wr(fsp_pkg::OFS_DATA, {24'h00_0000, d});
		wr(fsp_pkg::OFS_CMD, {29'h0000_0000, op});
		do xfer(1'b0, fsp_pkg::OFS_STATUS, 32'h0000_0000, st); while (st[fsp_pkg::ST_BUSY_BIT] !== 1'b0);
	endtask : cmd
	task automatic pv(input logic [20:0] a);
		cmd(fsp_pkg::OP_PROTECT, a, 8'h00);
		cmd(fsp_pkg::OP_VERIFY, a, 8'h00);
	endtask : pv
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		rchk("ctrl", fsp_pkg::OFS_CTRL, 32'h0000_0000);
		rchk("shadow", fsp_pkg::OFS_SHADOW, 32'h0000_0000);
		chk("guard", 32'h0000_0000, {31'h0, guard});
		wr(8'h18, 32'hFFFF_FFFF);
		rchk("unmapped", 8'h18, 32'h0000_0000);
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
		wr(fsp_pkg::OFS_CTRL, 32'h0000_0003);
		#1 chk("hv", 32'h0000_0001, {31'h0, fl_reset_hv_en});
		mask = 32'h0000_0000;
		for (int i = 0; i < 12; i++) begin
			pv({MAP_HI[i], 12'h000});
			mask[MAP_G[i]] = 1'b1;
			rchk("shadow", fsp_pkg::OFS_SHADOW, mask);
		end
		cmd(fsp_pkg::OP_UNPROT, 21'h00_0000, 8'h00);
		chk("err", 32'h0000_0001, {31'h0, st[fsp_pkg::ST_ERR_BIT]});
		for (int g = 1; g < 7; g++) pv(21'(g) << 12);
		for (int p = 2; p < 14; p++) pv(21'(p) << 17);
		rchk("shadow", fsp_pkg::OFS_SHADOW, 32'h01FF_FFFF);
		cmd(fsp_pkg::OP_UNPROT, 21'h00_0000, 8'h00);
		chk("err", 32'h0000_0000, {31'h0, st[fsp_pkg::ST_ERR_BIT]});
		chk("prot", 32'h0000_0000, {7'h00, u_flash.prot});
		wr(fsp_pkg::OFS_CTRL, 32'h0000_0001);
		cmd(fsp_pkg::OP_PROTECT, 21'h00_2000, 8'h00);
		chk("err", 32'h0000_0001, {31'h0, st[fsp_pkg::ST_ERR_BIT]});
		wr(fsp_pkg::OFS_CTRL, 32'h0000_0003);
		pv(21'h00_2000);
		foreach (rows[i]) begin
			wr(fsp_pkg::OFS_CTRL, {30'h0000_0000, rows[i].ctrl});
			cmd(fsp_pkg::OP_WRITE, {rows[i].hi, 12'h100}, rows[i].wd);
			cmd(fsp_pkg::OP_READ, {rows[i].hi, 12'h100}, 8'h00);
			rchk("data", fsp_pkg::OFS_DATA, {24'h00_0000, rows[i].exp});
		end
		cmd(fsp_pkg::OP_ENTER, 21'h00_0000, 8'h00);
		chk("secured", 32'h0000_0001, {31'h0, st[fsp_pkg::ST_SECURED_BIT]});
		cmd(fsp_pkg::OP_READ, 21'h00_7100, 8'h00);
		rchk("data", fsp_pkg::OFS_DATA, 32'h0000_00C3);
		cmd(fsp_pkg::OP_READ, 21'h04_0100, 8'h00);
		chk("err", 32'h0000_0001, {31'h0, st[fsp_pkg::ST_ERR_BIT]});
		cmd(fsp_pkg::OP_HWRESET, 21'h00_0000, 8'h00);
		chk("secured", 32'h0000_0000, {31'h0, st[fsp_pkg::ST_SECURED_BIT]});
		cmd(fsp_pkg::OP_READ, 21'h00_0100, 8'h00);
		rchk("data", fsp_pkg::OFS_DATA, 32'h0000_00A5);
		wr(fsp_pkg::OFS_CMD, {29'h0000_0000, fsp_pkg::OP_READ});
		wr(fsp_pkg::OFS_CMD, {29'h0000_0000, fsp_pkg::OP_READ});
		do xfer(1'b0, fsp_pkg::OFS_STATUS, 32'h0000_0000, st); while (st[fsp_pkg::ST_BUSY_BIT] !== 1'b0);
		chk("err", 32'h0000_0001, {31'h0, st[fsp_pkg::ST_ERR_BIT]});
		rchk("data", fsp_pkg::OFS_DATA, 32'h0000_00A5);
		cmd(fsp_pkg::OP_READ, 21'h00_0003, 8'h00);
		xfer(1'b0, fsp_pkg::OFS_DATA, 32'h0000_0000, st);
		chk("indicator", 32'h0000_0000, {31'h0, st[7]});
		cmd(fsp_pkg::OP_ENTER, 21'h00_0000, 8'h00);
		cmd(fsp_pkg::OP_EXIT, 21'h00_0000, 8'h00);
		chk("secured", 32'h0000_0000, {31'h0, st[fsp_pkg::ST_SECURED_BIT]});
		cmd(fsp_pkg::OP_READ, 21'h04_0100, 8'h00);
		chk("err", 32'h0000_0000, {31'h0, st[fsp_pkg::ST_ERR_BIT]});
		rchk("data", fsp_pkg::OFS_DATA, 32'h0000_00FF);
		wr(fsp_pkg::OFS_CTRL, 32'h0000_0003);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1 chk("guard", 32'h0000_0000, {31'h0, guard});
		chk("hv", 32'h0000_0000, {31'h0, fl_reset_hv_en});
		@(posedge core_clk);
		sys_rst <= 1'b0;
		rchk("ctrl", fsp_pkg::OFS_CTRL, 32'h0000_0000);
		clk_en <= 1'b0;
		wr(fsp_pkg::OFS_CTRL, 32'h0000_0003);
		clk_en <= 1'b1;
		rchk("frozen ctrl", fsp_pkg::OFS_CTRL, 32'h0000_0000);
		wrap_up();
	end
endmodule : testbench
